// ===== design/ddc_params.svh
// Constants for the dual converter serial command port
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

`define DDC_WORD_BITS     24
`define DDC_CODE_BITS     16
`define DDC_CMD_MSB       23
`define DDC_CMD_LSB       20
`define DDC_ADR_MSB       19
`define DDC_ADR_LSB       16
`define DDC_CMD_WRITE     4'h0
`define DDC_CMD_UPDATE    4'h1
`define DDC_CMD_WR_UPD_ALL 4'h2
`define DDC_CMD_WR_UPD    4'h3
`define DDC_CMD_PWRDN     4'h4
`define DDC_CMD_NOP       4'hF
`define DDC_ADR_A         4'h0
`define DDC_ADR_B         4'h1
`define DDC_ADR_ALL       4'hF
`define DDC_CODE_RESET    16'h0000

`endif

// ===== design/ddc_pkg.sv
// Types for the dual converter serial command port
package ddc_pkg;
  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  adr;
    logic [15:0] data;
  } ddc_word_t;

  typedef struct packed {
    logic [15:0] code_a;
    logic [15:0] code_b;
  } ddc_codes_t;

  typedef enum logic [1:0] {
    DDC_IDLE,
    DDC_SHIFT
  } ddc_state_t;
endpackage

// ===== design/ddc_serial_port.sv
// Serial command receiver and double-buffered code registers, two channels
//
// How it works
// - Low chip_select_load enables clock, data and shift register; level sensitive.
// - With select low, one data bit is sampled on each rising serial clock.
// - Data word is code MSB first; all 16 data bits form the code.
// - While select is high, clock edges leave the shift register alone.
// - Rising select ends the transfer and executes the received word.
// - Command 0000 writes the input register of the addressed channel only.
// - Command 0001 copies input to converter register and powers channel up.
// - Command 0010 writes addressed input, then updates and powers up all.
// - Command 0011 writes and immediately updates the addressed channel.
// - Address 0000 picks channel A, 0001 channel B, 1111 both.
// - A write moves the full 16-bit data field into the input register.
// - Converter register code stays active until a later update.
// - Any update powers the selected channel up.
// - A 32-bit word with 8 leading padding bits is accepted too.
// - Reset puts both outputs at zero scale until write and update.
// - Command 0100 powers down the addressed channel or both.
// - Power-down leaves input and converter registers unchanged.
`timescale 1ns/10ps
`include "ddc_params.svh"

module ddc_serial_port
  import ddc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic        CS_LOAD,
  input  wire logic        SER_CLK,
  input  wire logic        SER_DATA,
  output logic [15:0]      CODE_A,
  output logic [15:0]      CODE_B,
  output logic             POWERED_A,
  output logic             POWERED_B,
  output logic             EXEC_PULSE,
  output logic [5:0]       BIT_COUNT
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic [1:0]  cs_sync_r;
  logic [1:0]  sck_sync_r;
  logic [1:0]  sdi_sync_r;
  logic        cs_prev_r;
  logic        sck_prev_r;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_sync_r  <= 2'h3;
      sck_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], CS_LOAD};
      sck_sync_r <= {sck_sync_r[0], SER_CLK};
      sdi_sync_r <= {sdi_sync_r[0], SER_DATA};
      cs_prev_r  <= cs_sync_r[1];
      sck_prev_r <= sck_sync_r[1];
    end
  end

  logic cs_low;
  logic sck_rise;
  logic cs_rise;
  logic sdi_s;
  // Data passes the same two stages as the clock, so setup holds
  assign cs_low   = !cs_sync_r[1];
  assign sck_rise = sck_sync_r[1] && !sck_prev_r;
  assign cs_rise  = cs_sync_r[1] && !cs_prev_r;
  assign sdi_s    = sdi_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state
  ddc_state_t state_r;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= DDC_IDLE;
    end else begin
      unique case (state_r)
        DDC_IDLE: begin
          if (cs_low) begin
            state_r <= DDC_SHIFT;
          end
        end
        DDC_SHIFT: begin
          if (!cs_low) begin
            state_r <= DDC_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register; 24 bits kept, older padding falls off the top
  logic [23:0] shift_r;
  logic [5:0]  count_r;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_r <= 24'h000000;
      count_r <= 6'h00;
    end else if (cs_low && sck_rise) begin
      shift_r <= {shift_r[22:0], sdi_s};
      if (count_r != 6'h3F) begin
        count_r <= count_r + 6'h01;
      end
    end else if (state_r == DDC_IDLE && cs_low) begin
      count_r <= 6'h00;                                   // New frame starts counting
    end
  end
  // Edges while deselected fall through and change nothing
  assign BIT_COUNT = count_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode on the rising select edge
  ddc_word_t word;
  assign word = ddc_word_t'(shift_r);

  logic sel_a;
  logic sel_b;
  logic do_write;
  logic do_upd_sel;
  logic do_upd_all;
  logic do_pwrdn;
  // Short frames (under 24 bits) are executed as received; host must not send them
  always_comb begin
    sel_a      = (word.adr == `DDC_ADR_A) || (word.adr == `DDC_ADR_ALL);
    sel_b      = (word.adr == `DDC_ADR_B) || (word.adr == `DDC_ADR_ALL);
    do_write   = 1'b0;
    do_upd_sel = 1'b0;
    do_upd_all = 1'b0;
    do_pwrdn   = 1'b0;
    if (cs_rise) begin
      case (word.cmd)
        `DDC_CMD_WRITE: do_write = 1'b1;
        `DDC_CMD_UPDATE: do_upd_sel = 1'b1;
        `DDC_CMD_WR_UPD_ALL: begin
          do_write   = 1'b1;
          do_upd_all = 1'b1;
        end
        `DDC_CMD_WR_UPD: begin
          do_write   = 1'b1;
          do_upd_sel = 1'b1;
        end
        `DDC_CMD_PWRDN: do_pwrdn = 1'b1;
        default: do_write = 1'b0;             // No-op and reserved codes ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input registers per channel; write value bypasses into update
  logic [15:0] in_a_r;
  logic [15:0] in_b_r;
  logic [15:0] in_a_nxt;
  logic [15:0] in_b_nxt;

  assign in_a_nxt = (do_write && sel_a) ? word.data : in_a_r;
  assign in_b_nxt = (do_write && sel_b) ? word.data : in_b_r;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_a_r <= `DDC_CODE_RESET;
      in_b_r <= `DDC_CODE_RESET;
    end else begin
      in_a_r <= in_a_nxt;
      in_b_r <= in_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter registers and power state
  logic upd_a;
  logic upd_b;
  assign upd_a = do_upd_all || (do_upd_sel && sel_a);
  assign upd_b = do_upd_all || (do_upd_sel && sel_b);

  ddc_codes_t codes_r;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      codes_r <= '{code_a: `DDC_CODE_RESET, code_b: `DDC_CODE_RESET};
    end else begin
      if (upd_a) begin
        codes_r.code_a <= in_a_nxt;
      end
      if (upd_b) begin
        codes_r.code_b <= in_b_nxt;
      end
    end
  end
  // Power-down touches only the power flags, never the codes

  logic pwr_a_r;
  logic pwr_b_r;
  // Update wins if both could act; they never share a command anyway
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_a_r <= 1'b1;
      pwr_b_r <= 1'b1;
    end else begin
      if (upd_a) begin
        pwr_a_r <= 1'b1;
      end else if (do_pwrdn && sel_a) begin
        pwr_a_r <= 1'b0;
      end
      if (upd_b) begin
        pwr_b_r <= 1'b1;
      end else if (do_pwrdn && sel_b) begin
        pwr_b_r <= 1'b0;
      end
    end
  end

  logic exec_r;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      exec_r <= 1'b0;
    end else begin
      exec_r <= cs_rise;
    end
  end

  assign CODE_A     = codes_r.code_a;
  assign CODE_B     = codes_r.code_b;
  assign POWERED_A  = pwr_a_r;
  assign POWERED_B  = pwr_b_r;
  assign EXEC_PULSE = exec_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  shift_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !cs_low |=> $stable(shift_r))
    else $error("shift register moved while deselected");

  shift_in_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_low && sck_rise) |=> (shift_r[0] == $past(sdi_s)))
    else $error("sampled bit not shifted in");

  write_only_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_WRITE && word.adr == `DDC_ADR_A)
      |=> (in_a_r == $past(word.data)) && $stable(codes_r))
    else $error("write command misbehaved");

  update_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_UPDATE && word.adr == `DDC_ADR_A)
      |=> (CODE_A == $past(in_a_r)) && POWERED_A && $stable(in_a_r))
    else $error("update command misbehaved");

  // The untouched channel must load its own input, not the new data
  wr_upd_all_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_WR_UPD_ALL && word.adr == `DDC_ADR_B)
      |=> (CODE_B == $past(word.data)) && (CODE_A == $past(in_a_r))
          && POWERED_A && POWERED_B)
    else $error("write and update all misbehaved");

  // Single-channel update must leave the other code where it was
  wr_upd_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_WR_UPD && word.adr == `DDC_ADR_B)
      |=> (CODE_B == $past(word.data)) && $stable(CODE_A) && POWERED_B)
    else $error("write and update misbehaved");

  // Broadcast write fills both input registers with the full field
  write_all_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_WRITE && word.adr == `DDC_ADR_ALL)
      |=> (in_a_r == $past(word.data)) && (in_b_r == $past(word.data)))
    else $error("broadcast write misbehaved");

  // Any update of channel A leaves it powered, whatever came before
  power_up_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    upd_a |=> POWERED_A)
    else $error("update did not power channel up");

  pwrdn_keep_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (cs_rise && word.cmd == `DDC_CMD_PWRDN && word.adr == `DDC_ADR_ALL)
      |=> !POWERED_A && !POWERED_B && $stable(codes_r) && $stable(in_a_r))
    else $error("power down misbehaved");

  code_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !cs_rise |=> $stable(codes_r))
    else $error("code changed without a command");

  exec_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cs_rise |=> EXEC_PULSE ##1 !EXEC_PULSE)
    else $error("execute pulse wrong");

  // Main scenarios: both frame lengths, wake after sleep, odd codes, stray edges
  frame24_c: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cs_rise && count_r == 6'h18);
  frame32_c: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cs_rise && count_r == 6'h20);
  reserved_c: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cs_rise && !sel_a && !sel_b);
  stray_c: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !cs_low && sck_rise);
  pwrdn_c: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    do_pwrdn ##[1:1000] upd_a);

endmodule

// ===== tb/ddc_host_model.sv
// Host-side serial master model that drives command frames into the port
`timescale 1ns/10ps

module ddc_host_model (
  output logic cs_load_n,
  output logic ser_clk,
  output logic ser_data
);
  // Half of the 80 ns link clock period
  localparam time HALF = 40ns;

  ////////////////////////////////////////////////////////////////////////
  // Idle: deselected, link clock parked low
  initial begin
    cs_load_n = 1'b1;
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame of n bits, first bit is bits[n-1]; clock runs only inside the frame here, stray() clocks outside frames
  task automatic send(input logic [31:0] bits, input int n);
    cs_load_n = 1'b0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = bits[i];
      #HALF ser_clk = 1'b1;
      #HALF ser_clk = 1'b0;
    end
    #HALF cs_load_n = 1'b1;
    ser_data = ~ser_data;  // Released line must not look like the last bit
    #HALF;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Stray clock edges while deselected, data toggling so leaks would show
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      ser_data = ~ser_data;
      #HALF ser_clk = 1'b1;
      #HALF ser_clk = 1'b0;
    end
    #HALF;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the dual converter serial command port
`timescale 1ns/10ps
`include "ddc_params.svh"

module testbench
  import ddc_pkg::*;
;
  typedef struct packed {
    ddc_word_t  w;
    logic [7:0] pad;
    logic       lng;
    ddc_codes_t exp;
    logic [1:0] pwr;
  } ddc_row_t;

  localparam int NROW = 14;

  logic        SYS_CLK;
  logic        ARST_N;
  logic        CS_LOAD;
  logic        SER_CLK;
  logic        SER_DATA;
  logic [15:0] CODE_A;
  logic [15:0] CODE_B;
  logic        POWERED_A;
  logic        POWERED_B;
  logic        EXEC_PULSE;
  logic [5:0]  BIT_COUNT;
  int          bad_count = 0;
  int          checks = 0;
  int          pulses = 0;

  // Rows: command word, pad, 32-bit flag, expected codes, expected power {A,B}
  ddc_row_t rows [NROW] = '{
    '{'{`DDC_CMD_WRITE, `DDC_ADR_A, 16'h1234}, 8'h00, 1'b0, '{16'h0000, 16'h0000}, 2'h3},
    '{'{`DDC_CMD_UPDATE, `DDC_ADR_A, 16'hFFFF}, 8'hA5, 1'b1, '{16'h1234, 16'h0000}, 2'h3},
    '{'{`DDC_CMD_PWRDN, `DDC_ADR_B, 16'h5555}, 8'h00, 1'b0, '{16'h1234, 16'h0000}, 2'h2},
    '{'{`DDC_CMD_WRITE, `DDC_ADR_B, 16'hABCD}, 8'h30, 1'b1, '{16'h1234, 16'h0000}, 2'h2},
    '{'{`DDC_CMD_WR_UPD, `DDC_ADR_B, 16'h5678}, 8'h00, 1'b0, '{16'h1234, 16'h5678}, 2'h3},
    '{'{`DDC_CMD_PWRDN, `DDC_ADR_ALL, 16'h0000}, 8'h00, 1'b0, '{16'h1234, 16'h5678}, 2'h0},
    '{'{`DDC_CMD_WRITE, `DDC_ADR_A, 16'h8001}, 8'h00, 1'b0, '{16'h1234, 16'h5678}, 2'h0},
    '{'{`DDC_CMD_WR_UPD_ALL, `DDC_ADR_B, 16'h0F0F}, 8'hFF, 1'b1, '{16'h8001, 16'h0F0F}, 2'h3},
    '{'{`DDC_CMD_WRITE, `DDC_ADR_ALL, 16'hC3C3}, 8'h00, 1'b0, '{16'h8001, 16'h0F0F}, 2'h3},
    '{'{`DDC_CMD_UPDATE, `DDC_ADR_ALL, 16'h0000}, 8'h00, 1'b0, '{16'hC3C3, 16'hC3C3}, 2'h3},
    '{'{4'h5, `DDC_ADR_A, 16'hDEAD}, 8'h00, 1'b0, '{16'hC3C3, 16'hC3C3}, 2'h3},
    '{'{`DDC_CMD_NOP, `DDC_ADR_A, 16'h1111}, 8'h00, 1'b0, '{16'hC3C3, 16'hC3C3}, 2'h3},
    '{'{`DDC_CMD_WR_UPD, `DDC_ADR_A, 16'hFFFF}, 8'h00, 1'b0, '{16'hFFFF, 16'hC3C3}, 2'h3},
    '{'{`DDC_CMD_WR_UPD, 4'h2, 16'h2222}, 8'h00, 1'b0, '{16'hFFFF, 16'hC3C3}, 2'h3}
  };

  ddc_serial_port dut (
    .SYS_CLK    (SYS_CLK),
    .ARST_N     (ARST_N),
    .CS_LOAD    (CS_LOAD),
    .SER_CLK    (SER_CLK),
    .SER_DATA   (SER_DATA),
    .CODE_A     (CODE_A),
    .CODE_B     (CODE_B),
    .POWERED_A  (POWERED_A),
    .POWERED_B  (POWERED_B),
    .EXEC_PULSE (EXEC_PULSE),
    .BIT_COUNT  (BIT_COUNT)
  );

  ddc_host_model host (
    .cs_load_n (CS_LOAD),
    .ser_clk   (SER_CLK),
    .ser_data  (SER_DATA)
  );

  ////////////////////////////////////////////////////////////////////////
  // 125 MHz system clock
  initial SYS_CLK = 1'b0;
  always #4 SYS_CLK = ~SYS_CLK;

  // Count execute pulses; a stuck-high pulse shows up as too many
  always @(posedge SYS_CLK) begin
    if (EXEC_PULSE === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Active codes and power state together
  task automatic outs(input ddc_codes_t e, input logic [1:0] p);
    check("CODES", {CODE_A, CODE_B}, e);
    check("POWERED", 32'({POWERED_A, POWERED_B}), 32'(p));
  endtask

  task automatic conclude();
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is about 38 us; this cuts a hang short
  initial begin
    #300us;
    bad_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ARST_N = 1'b0;
    repeat (12) @(posedge SYS_CLK);
    #1 ARST_N = 1'b1;
    outs('{16'h0000, 16'h0000}, 2'h3);
    repeat (3) @(posedge SYS_CLK);
    #1;
    for (int i = 0; i < NROW; i++) begin
      host.send({rows[i].pad, rows[i].w}, rows[i].lng ? 32 : 24);
      repeat (2) @(posedge SYS_CLK);
      #1;
      check("BIT_COUNT", 32'(BIT_COUNT), rows[i].lng ? 32'h20 : 32'h18);
      check("EXEC_PULSE count", 32'(pulses), 32'(i + 1));
      outs(rows[i].exp, rows[i].pwr);
      check("ROW", 32'({POWERED_A, POWERED_B}), 32'(rows[i].pwr));
    end
    // Stray edges while deselected must neither count nor shift
    host.stray(5);
    check("BIT_COUNT idle", 32'(BIT_COUNT), 32'h18);
    check("EXEC_PULSE idle", 32'(pulses), 32'(NROW));
    host.send({8'h00, `DDC_CMD_UPDATE, `DDC_ADR_A, 16'h0000}, 24);
    repeat (2) @(posedge SYS_CLK);
    #1;
    check("CODE_A stray", 32'(CODE_A), 32'h0000FFFF);
    // Reset in mid-run after a power-down; input registers must clear too
    host.send({8'h00, `DDC_CMD_PWRDN, `DDC_ADR_A, 16'h0000}, 24);
    outs('{16'hFFFF, 16'hC3C3}, 2'h1);
    ARST_N = 1'b0;
    repeat (12) @(posedge SYS_CLK);
    #1;
    outs('{16'h0000, 16'h0000}, 2'h3);
    ARST_N = 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    host.send({8'h00, `DDC_CMD_UPDATE, `DDC_ADR_ALL, 16'hFFFF}, 24);
    repeat (2) @(posedge SYS_CLK);
    #1;
    outs('{16'h0000, 16'h0000}, 2'h3);
    conclude();
  end
endmodule
